/* design/drpwm_top.sv */
// dual resolution pwm unit: apb registers, timing generator, five channels
`timescale 1ns/1ps
`default_nettype none
module drpwm_top #(
    parameter int TAU_CYC = drpwm_pkg::TAU_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    output var  logic        wide_channel_output,
    output var  logic        wide_channel_oe,
    output var  logic        narrow_channel_a_output,
    output var  logic        narrow_channel_a_oe,
    output var  logic        narrow_channel_b_output,
    output var  logic        narrow_channel_b_oe,
    output var  logic        narrow_channel_c_output,
    output var  logic        narrow_channel_c_oe,
    output var  logic        narrow_channel_d_output,
    output var  logic        narrow_channel_d_oe
);

    drpwm_pkg::drpwm_state_t s_r;
    drpwm_pkg::drpwm_state_t s_nxt;
    logic       tick;
    logic       bound6;
    logic       bound8;
    logic       wide_wave;
    logic [3:0] nar_wave;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // lowest set bit j of the index picks value bit 5-j; index 0 never
    function automatic logic pulse_hit(input logic [5:0] idx, input logic [5:0] v);
        logic r;
        r = 1'b0;
        for (int j = 5; j >= 0; j--) begin
            if (idx[j]) begin
                r = v[5-j];
            end
        end
        return r;
    endfunction : pulse_hit

    function automatic logic at_idx(input logic [11:0] a, input logic [7:0] idx);
        return a == {2'h0, idx, 2'h0};
    endfunction : at_idx

    // ------------------------------------------------------------
    // timing generator and waveforms
    // ------------------------------------------------------------
    // one unit tick feeds every channel so all periods stay phase locked
    always_comb begin
        tick      = s_r.pre == 7'(TAU_CYC - 1);                       // RULE20 RULE18
        bound8    = tick && (s_r.tb[7:0] == 8'hff);
        bound6    = tick && (s_r.tb[10:0] == 11'h7ff);                 // RULE19
        // coarse high for N units, plus one unit in chosen sub-periods
        wide_wave = (s_r.tb[7:0] < s_r.up_lat)                         // RULE14 RULE13
                  || ((s_r.tb[7:0] == s_r.up_lat)
                      && pulse_hit(s_r.tb[13:8], s_r.lo_lat));         // RULE15
        for (int k = 0; k < 4; k++) begin
            // segment index is bits 10:5, so a segment is 32 units
            nar_wave[k] = pulse_hit(s_r.tb[10:5], s_r.nar_lat[6*k +: 6]); // RULE10 RULE11 RULE12
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt     = s_r;
        s_nxt.pre = tick ? 7'h00 : s_r.pre + 7'h01;
        if (tick) begin
            s_nxt.tb = s_r.tb + 14'h0001;                              // RULE17
        end
        // narrow latches reload on every narrow period boundary
        if (bound6) begin
            s_nxt.nar_lat = s_r.nar_reg;                               // RULE4
        end
        // the wide pair moves only after a lower write, so a lone upper
        // write never lands half a value in the latch
        if (bound8 && s_r.pend) begin
            s_nxt.up_lat = s_r.up_reg;                                 // RULE5
            s_nxt.lo_lat = s_r.lo_reg;
            s_nxt.pend   = 1'b0;                                       // RULE9
        end
        // apb: one wait cycle, answer registered
        if (psel && penable && !s_r.pready) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata  = 32'h0000_0000;
            // narrow latch top bits read as zero
            if (at_idx(paddr, drpwm_pkg::IDX_WIDE_UP)) begin
                s_nxt.prdata[7:0] = s_r.up_lat;                        // RULE7
            end else if (at_idx(paddr, drpwm_pkg::IDX_WIDE_LO)) begin
                s_nxt.prdata[7:0] = {s_r.pend, 1'b0, s_r.lo_lat};      // RULE9
            end else if (at_idx(paddr, drpwm_pkg::IDX_NARROW_A)) begin
                s_nxt.prdata[5:0] = s_r.nar_lat[5:0];                  // RULE8
            end else if (at_idx(paddr, drpwm_pkg::IDX_NARROW_B)) begin
                s_nxt.prdata[5:0] = s_r.nar_lat[11:6];
            end else if (at_idx(paddr, drpwm_pkg::IDX_NARROW_C)) begin
                s_nxt.prdata[5:0] = s_r.nar_lat[17:12];
            end else if (at_idx(paddr, drpwm_pkg::IDX_NARROW_D)) begin
                s_nxt.prdata[5:0] = s_r.nar_lat[23:18];
            end else if (at_idx(paddr, drpwm_pkg::IDX_OUT_SEL)) begin
                s_nxt.prdata[4:0] = s_r.sel;
            end else if (at_idx(paddr, drpwm_pkg::IDX_PORT_DIR)) begin
                s_nxt.prdata[4:0] = s_r.dir;
            end else begin
                s_nxt.pslverr = 1'b1;
            end
        end else if (s_r.pready) begin
            s_nxt.pready  = 1'b0;
            s_nxt.pslverr = 1'b0;
            // write lands at the completing edge; a set of pend beats the clear
            if (psel && penable && pwrite) begin
                if (at_idx(paddr, drpwm_pkg::IDX_WIDE_UP)) begin
                    s_nxt.up_reg = pwdata[7:0];
                end else if (at_idx(paddr, drpwm_pkg::IDX_WIDE_LO)) begin
                    s_nxt.lo_reg = pwdata[5:0];                        // RULE2
                    s_nxt.pend   = 1'b1;                               // RULE9
                end else if (at_idx(paddr, drpwm_pkg::IDX_NARROW_A)) begin
                    s_nxt.nar_reg[5:0] = pwdata[5:0];                  // RULE3
                end else if (at_idx(paddr, drpwm_pkg::IDX_NARROW_B)) begin
                    s_nxt.nar_reg[11:6] = pwdata[5:0];
                end else if (at_idx(paddr, drpwm_pkg::IDX_NARROW_C)) begin
                    s_nxt.nar_reg[17:12] = pwdata[5:0];
                end else if (at_idx(paddr, drpwm_pkg::IDX_NARROW_D)) begin
                    s_nxt.nar_reg[23:18] = pwdata[5:0];
                end else if (at_idx(paddr, drpwm_pkg::IDX_OUT_SEL)) begin
                    s_nxt.sel = pwdata[4:0];
                end else if (at_idx(paddr, drpwm_pkg::IDX_PORT_DIR)) begin
                    s_nxt.dir = pwdata[4:0];
                end
            end
        end
        // pins: waves from latches only, driven once both enables are set
        s_nxt.pin = {nar_wave, wide_wave};                             // RULE6
        s_nxt.oe  = s_r.sel & s_r.dir;                                 // RULE1
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // data reset to zero; pins start released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r         <= '0;                                         // RULE16
            s_r.up_reg  <= drpwm_pkg::DATA_RST;
            s_r.up_lat  <= drpwm_pkg::DATA_RST;
            s_r.sel     <= drpwm_pkg::CTRL_RST;
            s_r.dir     <= drpwm_pkg::CTRL_RST;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign prdata                  = s_r.prdata;
    assign pready                  = s_r.pready;
    assign pslverr                 = s_r.pslverr;
    assign wide_channel_output     = s_r.pin[0];
    assign wide_channel_oe         = s_r.oe[0];
    assign narrow_channel_a_output = s_r.pin[1];
    assign narrow_channel_a_oe     = s_r.oe[1];
    assign narrow_channel_b_output = s_r.pin[2];
    assign narrow_channel_b_oe     = s_r.oe[2];
    assign narrow_channel_c_output = s_r.pin[3];
    assign narrow_channel_c_oe     = s_r.oe[3];
    assign narrow_channel_d_output = s_r.pin[4];
    assign narrow_channel_d_oe     = s_r.oe[4];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_lo_write;
        psel && penable && pwrite && s_r.pready && clk_en
            && at_idx(paddr, drpwm_pkg::IDX_WIDE_LO);
    endsequence

    sequence s_a_write;
        psel && penable && pwrite && s_r.pready && clk_en
            && at_idx(paddr, drpwm_pkg::IDX_NARROW_A);
    endsequence

    // ------------------------------------------------------------
    // pin enable checks
    // ------------------------------------------------------------
    // the enable lags select and direction by exactly one enabled edge
    a_pin_enable_gate: assert property (                               // RULE1
        (clk_en && !(s_r.sel[0] && s_r.dir[0])) |=> !wide_channel_oe)
        else $error("wide pin driven without select and direction");

    a_pin_enable_set: assert property (                                // RULE1
        (clk_en && s_r.sel[4] && s_r.dir[4]) |=> narrow_channel_d_oe)
        else $error("narrow pin released with select and direction set");

    // ------------------------------------------------------------
    // register and latch checks
    // ------------------------------------------------------------

    a_narrow_low_six: assert property (s_a_write |=>                   // RULE3
        s_r.nar_reg[5:0] == $past(pwdata[5:0]))
        else $error("narrow register kept wrong bits");

    a_narrow_boundary: assert property (                               // RULE4
        $changed(s_r.nar_lat) |-> $past(bound6 && clk_en))
        else $error("narrow latch changed off boundary");

    a_wide_boundary: assert property (                                 // RULE5
        $changed({s_r.up_lat, s_r.lo_lat}) |-> $past(bound8 && s_r.pend && clk_en))
        else $error("wide latch changed off coarse boundary");

    a_pend_flag_set: assert property (s_lo_write |=> s_r.pend)          // RULE9
        else $error("pending bit not set after lower write");

    // pending stays up until the coarse boundary that carries the pair
    a_pend_flag_hold: assert property (                                // RULE9
        (s_r.pend && !(bound8 && clk_en)) |=> s_r.pend)
        else $error("pending bit dropped before transfer");

    a_pend_flag_clear: assert property (                               // RULE9
        (bound8 && clk_en && s_r.pend && !s_r.pready) |=> !s_r.pend)
        else $error("pending bit kept after transfer");

    a_wide_reload: assert property (                                   // RULE5
        (bound8 && clk_en && s_r.pend)
        |=> {s_r.up_lat, s_r.lo_lat} == $past({s_r.up_reg, s_r.lo_reg}))
        else $error("wide latch loaded wrong value");

    a_narrow_reload: assert property (                                 // RULE4
        (bound6 && clk_en) |=> s_r.nar_lat == $past(s_r.nar_reg))
        else $error("narrow latch loaded wrong value");

    // the answer stands one cycle so a master never sees it twice
    a_ready_pulse: assert property (                                   // RULE7
        (clk_en && s_r.pready) |=> !pready)
        else $error("ready held longer than one cycle");

    a_err_with_ready: assert property (                                // RULE7
        pslverr |-> pready)
        else $error("error flag without ready");

    a_read_latch: assert property (                                    // RULE7
        (s_r.pready && !pwrite && at_idx(paddr, drpwm_pkg::IDX_NARROW_A)
            && $past(clk_en))
        |-> prdata[5:0] == $past(s_r.nar_lat[5:0]))
        else $error("narrow read not from latch");

    // ------------------------------------------------------------
    // waveform checks, taken at the pins one cycle after the counter
    // ------------------------------------------------------------
    // segment zero low on every narrow channel rules out a full high period
    a_no_full_high: assert property (                                  // RULE12
        (clk_en && s_r.tb[10:5] == 6'h00)
        |=> !(narrow_channel_a_output || narrow_channel_b_output
              || narrow_channel_c_output || narrow_channel_d_output))
        else $error("narrow output high in segment zero");

    // odd segments belong to the heaviest latch bit
    a_narrow_odd_seg: assert property (                                // RULE10
        (clk_en && s_r.tb[5]) |=> narrow_channel_a_output == $past(s_r.nar_lat[5]))
        else $error("narrow odd segment not from latch bit five");

    // segment 32 alone belongs to the lightest latch bit
    a_narrow_mid_seg: assert property (                                // RULE11
        (clk_en && s_r.tb[10:5] == 6'h20)
        |=> narrow_channel_d_output == $past(s_r.nar_lat[18]))
        else $error("narrow middle segment not from latch bit zero");

    a_coarse_width: assert property (                                  // RULE14
        (clk_en && s_r.tb[7:0] < s_r.up_lat) |=> wide_channel_output)
        else $error("coarse pulse too short");

    a_coarse_low: assert property (                                    // RULE13
        (clk_en && s_r.tb[7:0] > s_r.up_lat) |=> !wide_channel_output)
        else $error("coarse pulse too long");

    // the fine unit sits right after the coarse pulse of a sub-period
    sequence s_fine_slot;
        clk_en && s_r.tb[7:0] == s_r.up_lat;
    endsequence

    a_fine_mid_slot: assert property (                                 // RULE15
        s_fine_slot ##0 (s_r.tb[13:8] == 6'h20)
        |=> wide_channel_output == $past(s_r.lo_lat[0]))
        else $error("sub-period 32 not lengthened by fine bit zero");

    a_fine_odd_slot: assert property (                                 // RULE15
        s_fine_slot ##0 s_r.tb[8]
        |=> wide_channel_output == $past(s_r.lo_lat[5]))
        else $error("odd sub-period not lengthened by fine bit five");

    a_sub_wrap: assert property (                                      // RULE17
        (tick && clk_en && s_r.tb == 14'h3fff) |=> s_r.tb == 14'h0000)
        else $error("sub-period index did not wrap");

endmodule : drpwm_top
`default_nettype wire

/* inc/drpwm_pkg.sv */
// constants and state type of the dual resolution pwm unit
//
// What this block does
// [RULE1] pin driven only with select and direction set
// [RULE2] software writes upper byte before lower byte
// [RULE3] narrow registers drop the top two bits
// [RULE4] narrow latch reloads once per narrow period
// [RULE5] wide latch reloads at next coarse period
// [RULE6] waveforms come only from latch contents
// [RULE7] data register reads return the latch
// [RULE8] narrow latch reads: top bits undefined
// [RULE9] lower register bit 7 shows transfer pending
// [RULE10] narrow period: 64 segments, weighted pulse trains
// [RULE11] narrow duty 0/64 to 63/64 by latch
// [RULE12] narrow output never high whole period
// [RULE13] wide latch splits coarse byte, fine six bits
// [RULE14] coarse pulse N units per 256 unit sub-period
// [RULE15] fine bits lengthen chosen sub-periods by one unit
// [RULE16] pins high impedance after reset
// [RULE17] 64 sub-periods, index wraps after 63
// [RULE18] time unit 500 ns, repeat 8192 us; code: 62 cycles at 125 MHz, unit 496 ns, repeat 8126.464 us
// [RULE19] narrow segment 16 us, repeat 1024 us; code: segment 15.872 us, repeat 1015.808 us
// [RULE20] one shared timing generator for all channels
package drpwm_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_WIDE_UP  = 8'hf0;
    localparam logic [7:0] IDX_WIDE_LO  = 8'hf1;
    localparam logic [7:0] IDX_NARROW_A = 8'hf2;
    localparam logic [7:0] IDX_NARROW_B = 8'hf3;
    localparam logic [7:0] IDX_NARROW_C = 8'hf4;
    localparam logic [7:0] IDX_NARROW_D = 8'hf8;
    localparam logic [7:0] IDX_OUT_SEL  = 8'hf9;
    localparam logic [7:0] IDX_PORT_DIR = 8'hfa;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int         PEND_BIT     = 7;
    localparam int         ADDR_W       = 12;
    localparam logic [7:0] DATA_RST     = 8'h00;
    localparam logic [4:0] CTRL_RST     = 5'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 125;
    localparam int TAU_NS        = 500;
    // 62.5 cycles per unit; a period-type time, rounded down
    localparam int TAU_CYC       = TAU_NS * CLK_MHZ / 1000;
    localparam int SUB_UNITS     = 256;
    localparam int SEG_UNITS     = 32;
    localparam int TB_W          = 14;

    typedef struct packed {
        logic [6:0]  pre;
        logic [13:0] tb;
        logic [7:0]  up_reg;
        logic [5:0]  lo_reg;
        logic [7:0]  up_lat;
        logic [5:0]  lo_lat;
        logic        pend;
        logic [23:0] nar_reg;
        logic [23:0] nar_lat;
        logic [4:0]  sel;
        logic [4:0]  dir;
        logic [4:0]  pin;
        logic [4:0]  oe;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } drpwm_state_t;

endpackage : drpwm_pkg

/* verification/drpwm_tb.sv */
// self-checking testbench of the dual resolution pwm unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ------------------------------------------------------------
    // signals and reference model state
    // ------------------------------------------------------------
    localparam int TAU = 2; // short unit so full periods fit in the run
    logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [4:0]  pin, oe;
    logic [7:0]  nv [4];
    logic [7:0]  nidx [4];
    logic [7:0]  wn, wf;
    int          error_cnt, n_tests;
    int          hc [5];
    int          exp_q [$];

    drpwm_top #(.TAU_CYC(TAU)) dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wide_channel_output(pin[0]), .wide_channel_oe(oe[0]),
        .narrow_channel_a_output(pin[1]), .narrow_channel_a_oe(oe[1]),
        .narrow_channel_b_output(pin[2]), .narrow_channel_b_oe(oe[2]),
        .narrow_channel_c_output(pin[3]), .narrow_channel_c_oe(oe[3]),
        .narrow_channel_d_output(pin[4]), .narrow_channel_d_oe(oe[4])
    );

    // 125 mhz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        chk("pready idle", 0, pready);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no cycle count assumed: only the watchdog ends a stuck wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // hang guard: the whole sequence needs about 45300 cycles
    initial begin
        repeat (60000) @(posedge pclk);
        error_cnt++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h00000000; error_cnt = 0; n_tests = 0;
        seed = 32'hfbe2e8bc;
        nidx = '{drpwm_pkg::IDX_NARROW_A, drpwm_pkg::IDX_NARROW_B,
                 drpwm_pkg::IDX_NARROW_C, drpwm_pkg::IDX_NARROW_D};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1 chk("pins after reset", 10'h000, {pin, oe});
        $display("test reset done");
        apb(1'b0, 8'h00, 8'h00);
        chk("unmapped err", 1, err);
        chk("unmapped data", 0, rd);
        for (int i = 0; i < 4; i++) begin
            seed  = lfsr(seed);
            nv[i] = seed[7:0];
        end
        nv[2] = 8'hff; // highest duty, top bits set
        nv[3] = 8'hc0; // only top bits: zero duty
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, nidx[i], nv[i]);
            exp_q.push_back(nv[i] % 64);
        end
        apb(1'b0, nidx[0], 8'h00);
        chk("narrow before reload", 0, rd[7:0]);
        seed = lfsr(seed);
        wn   = seed[7:0];
        wf   = seed[15:8];
        apb(1'b1, drpwm_pkg::IDX_WIDE_UP, wn);
        apb(1'b0, drpwm_pkg::IDX_WIDE_UP, 8'h00);
        chk("upper before lower", 0, rd[7:0]);
        apb(1'b1, drpwm_pkg::IDX_WIDE_LO, wf);
        apb(1'b0, drpwm_pkg::IDX_WIDE_LO, 8'h00);
        chk("lower pending", 8'h80, rd[7:0]);
        // longer than one narrow period so every latch has reloaded
        repeat (4200) @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, nidx[i], 8'h00);
            chk("narrow latch", exp_q.pop_front(), rd[7:0]);
        end
        apb(1'b0, drpwm_pkg::IDX_WIDE_UP, 8'h00);
        chk("upper latch", wn, rd[7:0]);
        apb(1'b0, drpwm_pkg::IDX_WIDE_LO, 8'h00);
        chk("lower done", {2'b00, wf[5:0]}, rd[7:0]);
        $display("test registers done");
        apb(1'b1, drpwm_pkg::IDX_OUT_SEL, 8'h1f);
        repeat (3) @(posedge pclk);
        #1 chk("oe select only", 0, oe);
        apb(1'b1, drpwm_pkg::IDX_PORT_DIR, 8'h1f);
        repeat (3) @(posedge pclk);
        #1 chk("oe both set", 5'h1f, oe);
        $display("test enables done");
        // one wide repeat period equals eight narrow periods: one window for all
        hc = '{default: 0};
        repeat (32768) begin
            @(posedge pclk);
            for (int k = 0; k < 5; k++) hc[k] += (pin[k] === 1'b1);
        end
        chk("wide high cycles", TAU * (64 * wn + wf[5:0]), hc[0]);
        for (int i = 0; i < 4; i++) begin
            chk("narrow high cycles", 8 * TAU * 32 * nv[i][5:0], hc[i + 1]);
        end
        $display("test duty done");
        // enable low every other cycle: one narrow period takes twice the cycles
        hc = '{default: 0};
        repeat (8192) begin
            @(posedge pclk);
            clk_en <= ~clk_en; // even count of toggles leaves it high
            for (int k = 1; k < 5; k++) hc[k] += (pin[k] === 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            chk("gated narrow high cycles", 2 * TAU * 32 * nv[i][5:0], hc[i + 1]);
        end
        $display("test enable done");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
